// >>> src/phph_host.sv
// Host end: register-driven sequencer that frames byte reads and writes
module phph_host
  import phph_pkg::*;
(
  input  wire logic        i_clk,   // System clock
  input  wire logic        i_rst_n, // Synchronous reset, active low
  phph_if.host             port,    // Pins toward the device
  input  wire logic [7:0]  i_addr,  // Register byte address
  input  wire logic [31:0] i_wdata, // Write data
  input  wire logic        i_wr,    // Write strobe
  input  wire logic        i_rd,    // Read strobe
  output logic      [31:0] o_rdata, // Read data, cycle after strobe
  output logic             o_irq    // Level interrupt
);

  // ==========================================================
  // State
  typedef struct packed {
    phph_hstate_t      fsm;      // Sequencer state
    logic [CNT_W-1:0]  cnt;      // Cycles left in phase
    logic              is_read;  // Current transfer is a read
    logic [CTRL_W-1:0] ctrl;     // Mode and select bits
    logic [7:0]        wdata;    // Byte to write
    logic [7:0]        rdata;    // Byte last read
    logic              done;     // Sticky completion event
    logic              mask;     // Completion enable
    logic              cs_n;     // Chip select pin
    logic              rd_s;     // Read strobe pin
    logic              wr_s;     // Write strobe pin
    logic              ds;       // Data strobe pin
    logic              rw;       // Direction pin
    logic              stat;     // Status select pin
    logic              half;     // Half select pin
    logic [7:0]        bus_out;  // Byte driven
    logic              bus_oe;   // Byte bus driven
    logic [31:0]       rd_out;   // Register read data
    logic              irq;      // Interrupt level
  } phph_host_t;

  phph_host_t st;       // Registered state
  phph_host_t next_st;  // Next state

  // ==========================================================
  // Next state
  always_comb
  begin
    logic ds_mode;  // Data-strobe signalling selected
    logic ds_pol;   // Data strobe active level
    logic set_done; // Transfer finished this cycle
    next_st  = st;
    ds_mode  = st.ctrl[CTRL_MODE_BIT];
    ds_pol   = st.ctrl[CTRL_DSPOL_BIT];
    set_done = 1'b0;
    next_st.rd_out = 32'h0000_0000;

    unique case (st.fsm)
      PHPH_IDLE:
      begin
        // Idle pins: chip select and strobes deasserted
        next_st.cs_n = 1'b1;
        next_st.rd_s = 1'b1;
        next_st.wr_s = 1'b1;
        next_st.ds   = ~ds_pol;
        if (i_wr && i_addr == REG_CMD
            && (i_wdata[CMD_READ_BIT] || i_wdata[CMD_WRITE_BIT]))
        begin
          // Selects and direction settle a full phase ahead of the frame
          next_st.is_read = i_wdata[CMD_READ_BIT];
          next_st.rw      = i_wdata[CMD_READ_BIT];
          next_st.stat    = st.ctrl[CTRL_STAT_BIT];
          next_st.half    = st.ctrl[CTRL_HALF_BIT];
          next_st.bus_out = st.wdata;
          next_st.bus_oe  = ~i_wdata[CMD_READ_BIT];
          next_st.cnt     = CNT_W'(SETUP_CYC);
          next_st.fsm     = PHPH_SETUP;
        end
      end
      PHPH_SETUP:
      begin
        next_st.cnt = st.cnt - 1'b1;
        if (st.cnt == CNT_W'(1))
        begin
          // Select and strobe together; direction line stays a level
          next_st.cs_n = 1'b0;
          next_st.rd_s = ~(~ds_mode & st.is_read);
          next_st.wr_s = ~(~ds_mode & ~st.is_read);
          next_st.ds   = ds_mode ? ds_pol : ~ds_pol;
          next_st.cnt  = CNT_W'(ACTIVE_CYC);
          next_st.fsm  = PHPH_ACTIVE;
        end
      end
      PHPH_ACTIVE:
      begin
        next_st.cnt = st.cnt - 1'b1;
        if (st.cnt == CNT_W'(1))
        begin
          if (st.is_read)
            next_st.rdata = port.host_byte_bus;
          // Select and strobes released together to close the frame
          next_st.cs_n = 1'b1;
          next_st.rd_s = 1'b1;
          next_st.wr_s = 1'b1;
          next_st.ds   = ~ds_pol;
          next_st.fsm  = PHPH_RELEASE;
        end
      end
      PHPH_RELEASE:
      begin
        // Write data and selects held one cycle past the frame end
        next_st.bus_oe = 1'b0;
        set_done       = 1'b1;
        next_st.fsm    = PHPH_IDLE;
      end
    endcase

    // Register writes; setup is frozen while a transfer runs
    if (i_wr)
    begin
      if (i_addr == REG_CTRL && st.fsm == PHPH_IDLE)
        next_st.ctrl = i_wdata[CTRL_W-1:0];
      if (i_addr == REG_WDATA && st.fsm == PHPH_IDLE)
        next_st.wdata = i_wdata[7:0];
      if (i_addr == REG_IRQ_MASK)
        next_st.mask = i_wdata[IRQ_DONE_BIT];
      if (i_addr == REG_IRQ_STAT && i_wdata[IRQ_DONE_BIT])
        next_st.done = 1'b0;
    end
    // An event in the clearing cycle is kept
    if (set_done)
      next_st.done = 1'b1;

    // Register reads, answered the next cycle; unmapped reads give zero
    if (i_rd)
    begin
      unique case (i_addr)
        REG_CTRL:     next_st.rd_out[CTRL_W-1:0] = st.ctrl;
        REG_CMD:      next_st.rd_out[0] = (st.fsm != PHPH_IDLE);
        REG_WDATA:    next_st.rd_out[7:0] = st.wdata;
        REG_RDATA:    next_st.rd_out[7:0] = st.rdata;
        REG_FLAGS:
        begin
          next_st.rd_out[FLG_OBE_BIT]  = port.out_buffer_empty_flag;
          next_st.rd_out[FLG_IBF_BIT]  = port.in_buffer_full_flag;
          next_st.rd_out[FLG_BUSY_BIT] = (st.fsm != PHPH_IDLE);
        end
        REG_IRQ_STAT: next_st.rd_out[IRQ_DONE_BIT] = st.done;
        REG_IRQ_MASK: next_st.rd_out[IRQ_DONE_BIT] = st.mask;
        default:      next_st.rd_out = 32'h0000_0000;
      endcase
    end

    next_st.irq = next_st.done & next_st.mask;
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st      <= '0;
      st.fsm  <= PHPH_IDLE;
      st.cs_n <= 1'b1;
      st.rd_s <= 1'b1;
      st.wr_s <= 1'b1;
      st.ds   <= 1'b1;
      st.rw   <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // Outputs
  assign port.host_chip_select_n  = st.cs_n;
  assign port.host_read_strobe    = st.rd_s;
  assign port.host_write_strobe   = st.wr_s;
  assign port.host_data_strobe    = st.ds;
  assign port.host_read_write_dir = st.rw;
  assign port.status_select       = st.stat;
  assign port.byte_half_select    = st.half;
  assign port.host_byte_from_host = st.bus_out;
  assign port.host_byte_host_oe   = st.bus_oe;
  assign o_rdata                  = st.rd_out;
  assign o_irq                    = st.irq;

endmodule

// >>> src/phph_pkg.sv
// Shared constants for both ends of the parallel host port handshake
package phph_pkg;

  // ==========================================================
  // Timing, kept in picoseconds so fractional figures stay exact
  localparam int CLK_PS    = 100000;  // 10 MHz clock period
  localparam int PULSE_PS  = 20500;   // Least strobe pulse width
  localparam int SETUP_PS  = 6000;    // Least select setup to frame start
  localparam int FLAG_PS   = 20000;   // Longest frame end to flag update
  localparam int PULSE_CYC = (PULSE_PS + CLK_PS - 1) / CLK_PS;  // Rounded up
  localparam int SETUP_CYC = (SETUP_PS + CLK_PS - 1) / CLK_PS;  // Rounded up
  localparam int FLAG_CYC  = (FLAG_PS / CLK_PS < 1) ? 1 : FLAG_PS / CLK_PS;
  // Device drives read data one edge after the frame start, so the host
  // keeps the frame open one cycle past the least pulse width.
  localparam int ACTIVE_CYC = PULSE_CYC + 1;
  localparam int CNT_W      = 4;      // Host phase counter width

  // ==========================================================
  // Controller register map (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;  // Mode and select bits
  localparam logic [7:0] REG_CMD      = 8'h04;  // Start read or write
  localparam logic [7:0] REG_WDATA    = 8'h08;  // Byte for next write
  localparam logic [7:0] REG_RDATA    = 8'h0c;  // Byte of last read
  localparam logic [7:0] REG_FLAGS    = 8'h10;  // Flag pins and busy
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;  // Sticky events, write one to clear
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;  // Event enables

  // Field positions
  localparam int CTRL_MODE_BIT  = 0;  // 1 = data-strobe mode
  localparam int CTRL_DSPOL_BIT = 1;  // 1 = data strobe active high
  localparam int CTRL_STAT_BIT  = 2;  // Status select level
  localparam int CTRL_HALF_BIT  = 3;  // Byte half select level
  localparam int CTRL_W         = 4;
  localparam int CMD_READ_BIT   = 0;
  localparam int CMD_WRITE_BIT  = 1;
  localparam int FLG_OBE_BIT    = 0;
  localparam int FLG_IBF_BIT    = 1;
  localparam int FLG_BUSY_BIT   = 2;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int STAT_OBE_BIT   = 0;  // Status byte: output buffer empty
  localparam int STAT_IBF_BIT   = 1;  // Status byte: input buffer full

  // Reset values
  localparam logic OBE_RST = 1'b1;   // Output buffer empty
  localparam logic IBF_RST = 1'b0;   // Input buffer not full

  // Host sequencer states
  typedef enum logic [1:0] {
    PHPH_IDLE    = 2'b00,
    PHPH_SETUP   = 2'b01,
    PHPH_ACTIVE  = 2'b10,
    PHPH_RELEASE = 2'b11
  } phph_hstate_t;

endpackage

// >>> src/phph_if.sv
// Pin bundle between the host and the device end of the port
interface phph_if;
  logic       host_chip_select_n;    // Chip select, active low
  logic       host_read_strobe;      // Split mode read strobe, active low
  logic       host_write_strobe;     // Split mode write strobe, active low
  logic       host_data_strobe;      // Data strobe, programmable level
  logic       host_read_write_dir;   // 1 = read, 0 = write
  logic       status_select;         // Read status byte instead of data
  logic       byte_half_select;      // 1 = high half of word
  logic [7:0] host_byte_from_host;   // Host output to byte bus
  logic       host_byte_host_oe;     // Host drives byte bus
  logic [7:0] host_byte_from_dev;    // Device output to byte bus
  logic       host_byte_dev_oe;      // Device drives byte bus
  logic       out_buffer_empty_flag; // Output buffer empty pin
  logic       in_buffer_full_flag;   // Input buffer full pin
  logic [7:0] host_byte_bus;         // Resolved bus level

  // Undriven bus floats high, as with pull-ups
  assign host_byte_bus = host_byte_dev_oe  ? host_byte_from_dev :
                         host_byte_host_oe ? host_byte_from_host : 8'hff;

  modport host (
    output host_chip_select_n, host_read_strobe, host_write_strobe, host_data_strobe,
    output host_read_write_dir, status_select, byte_half_select,
    output host_byte_from_host, host_byte_host_oe,
    input  host_byte_bus, out_buffer_empty_flag, in_buffer_full_flag
  );

  modport device (
    input  host_chip_select_n, host_read_strobe, host_write_strobe, host_data_strobe,
    input  host_read_write_dir, status_select, byte_half_select, host_byte_bus,
    output host_byte_from_dev, host_byte_dev_oe,
    output out_buffer_empty_flag, in_buffer_full_flag
  );
endinterface

// >>> src/phph_frame.sv
// Frame edge detector: start and end pulses from a combined active level
module phph_frame
  import phph_pkg::*;
(
  input  wire logic i_clk,    // System clock
  input  wire logic i_rst_n,  // Synchronous reset, active low
  input  wire logic i_active, // Both framing signals asserted
  output logic      o_start,  // Pulse: frame began this cycle
  output logic      o_end     // Pulse: frame ended this cycle
);

  // ==========================================================
  // State
  typedef struct packed {
    logic prev;  // Active level seen last cycle
  } phph_frame_t;

  phph_frame_t st;       // Registered state
  phph_frame_t next_st;  // Next state

  // The start is whichever signal asserts last, the end whichever
  // deasserts first, because only their conjunction is watched.
  always_comb
  begin
    next_st      = st;
    next_st.prev = i_active;
  end

  assign o_start = i_active & ~st.prev;
  assign o_end   = ~i_active & st.prev;

  // State register
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      st <= '0;
    else
      st <= next_st;
  end

endmodule

// >>> src/phph_device.sv
// Device end of the parallel host port: word buffers, flags, framing
module phph_device
  import phph_pkg::*;
(
  input  wire logic        i_clk,           // System clock
  input  wire logic        i_rst_n,         // Synchronous reset, active low
  phph_if.device           port,            // Host-facing pins
  input  wire logic        i_mode_ds,       // 1 = data-strobe mode
  input  wire logic        i_ds_active_high,// Data strobe active level
  input  wire logic        i_obe_invert,    // Invert empty flag pin
  input  wire logic        i_ibf_invert,    // Invert full flag pin
  input  wire logic        i_load,          // Pulse: load output word
  input  wire logic [15:0] i_load_word,     // Word for the host to read
  input  wire logic        i_take,          // Pulse: input word consumed
  output logic      [15:0] o_in_word,       // Word written by the host
  output logic             o_out_empty,     // Output buffer empty
  output logic             o_in_full        // Input buffer full
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] out_word;  // Output buffer
    logic        obe;       // Output buffer empty
    logic [15:0] in_word;   // Input buffer
    logic        ibf;       // Input buffer full
    logic        a_read;    // Kind of the frame on the first detector
    logic        half;      // Byte half latched at frame start
    logic        stat;      // Status select latched at frame start
    logic [7:0]  byte_out;  // Byte driven to the host
    logic        byte_oe;   // Byte bus driven
    logic        obe_pin;   // Empty flag pin level
    logic        ibf_pin;   // Full flag pin level
  } phph_dev_t;

  phph_dev_t st;       // Registered state
  phph_dev_t next_st;  // Next state

  // ==========================================================
  // Frame decode
  logic rd_pin_act;  // Split mode read frame level
  logic wr_pin_act;  // Split mode write frame level
  logic ds_act;      // Data-strobe mode frame level
  logic a_act;       // Level for detector A
  logic b_act;       // Level for detector B
  logic a_start;     // Detector A start pulse
  logic a_end;       // Detector A end pulse
  logic b_start;     // Detector B start pulse
  logic b_end;       // Detector B end pulse

  // Direction line is deliberately absent from every frame level
  assign rd_pin_act = ~port.host_chip_select_n & ~port.host_read_strobe;
  assign wr_pin_act = ~port.host_chip_select_n & ~port.host_write_strobe;
  assign ds_act     = ~port.host_chip_select_n
                    & (port.host_data_strobe == i_ds_active_high);
  // Detector A follows reads in split mode and every frame in strobe mode
  assign a_act = i_mode_ds ? ds_act : rd_pin_act;
  assign b_act = ~i_mode_ds & wr_pin_act;

  phph_frame u_frame_a (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_active (a_act),
    .o_start  (a_start),
    .o_end    (a_end)
  );

  phph_frame u_frame_b (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_active (b_act),
    .o_start  (b_start),
    .o_end    (b_end)
  );

  // ==========================================================
  // Helpers
  // Pick one half of a word
  function automatic logic [7:0] phph_half(input logic [15:0] w, input logic hi);
    phph_half = hi ? w[15:8] : w[7:0];
  endfunction

  // Merge a byte into one half of a word
  function automatic logic [15:0] phph_merge(input logic [15:0] w, input logic [7:0] b,
                                             input logic hi);
    phph_merge = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    logic        rd_start;  // Read frame begins
    logic        rd_end;    // Read frame completes
    logic        wr_end;    // Write frame completes
    logic        cur_half;  // Half for the frame just ending
    logic [7:0]  status;    // Port status byte
    next_st  = st;
    rd_start = 1'b0;
    rd_end   = 1'b0;
    wr_end   = 1'b0;
    cur_half = st.half;
    status   = 8'h00;
    status[STAT_OBE_BIT] = st.obe;
    status[STAT_IBF_BIT] = st.ibf;

    // Frame starts: latch selects once; host keeps them stable after
    if (a_start)
    begin
      // Direction sampled only as a level at the start edge
      next_st.a_read = i_mode_ds ? port.host_read_write_dir : 1'b1;
      next_st.half   = port.byte_half_select;
      next_st.stat   = port.status_select;
      rd_start       = i_mode_ds ? port.host_read_write_dir : 1'b1;
    end
    else if (b_start)
    begin
      next_st.half = port.byte_half_select;
      next_st.stat = port.status_select;
    end

    // Read: drive the selected byte or the status byte
    if (rd_start)
    begin
      next_st.byte_oe  = 1'b1;
      next_st.byte_out = port.status_select ? status
                       : phph_half(st.out_word, port.byte_half_select);
    end

    // Frame ends
    if (a_end)
    begin
      rd_end = st.a_read;
      wr_end = ~st.a_read;
    end
    if (b_end)
      wr_end = 1'b1;

    if (rd_end)
      next_st.byte_oe = 1'b0;

    // Write data taken at completion, while the host still drives it
    if (wr_end)
      next_st.in_word = phph_merge(st.in_word, port.host_byte_bus, cur_half);

    // Processor side: a fresh load marks the output buffer not empty.
    // A load coinciding with the last host read wins: the new word is unread.
    if (rd_end && !st.stat && cur_half)
      next_st.obe = 1'b1;
    if (i_load)
    begin
      next_st.out_word = i_load_word;
      next_st.obe      = 1'b0;
    end

    // Taking the input word clears full; a host write of the high half in the same cycle wins
    if (i_take)
      next_st.ibf = 1'b0;
    if (wr_end && cur_half)
      next_st.ibf = 1'b1;

    // Pins follow the new flag one edge after the frame end, a full clock
    // period and so past the flag deadline; the inversion leaves that timing unchanged.
    next_st.obe_pin = next_st.obe ^ i_obe_invert;
    next_st.ibf_pin = next_st.ibf ^ i_ibf_invert;
  end

  // ==========================================================
  // State register; reset drives the pins to the uninverted empty levels
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st         <= '0;
      st.obe     <= OBE_RST;
      st.ibf     <= IBF_RST;
      st.a_read  <= 1'b1;
      st.obe_pin <= OBE_RST;
      st.ibf_pin <= IBF_RST;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // Outputs, all straight from flops
  assign port.host_byte_from_dev    = st.byte_out;
  assign port.host_byte_dev_oe      = st.byte_oe;
  assign port.out_buffer_empty_flag = st.obe_pin;
  assign port.in_buffer_full_flag   = st.ibf_pin;
  assign o_in_word                  = st.in_word;
  assign o_out_empty                = st.obe;
  assign o_in_full                  = st.ibf;

endmodule

// >>> dv/phph_sva.sv
// Pin-level checker for the two ends of the parallel host port
module phph_sva (
  input wire logic       i_clk,                 // System clock
  input wire logic       i_rst_n,               // Reset, active low
  input wire logic       i_mode_ds,             // Data-strobe mode
  input wire logic       i_ds_active_high,      // Strobe level
  input wire logic       i_obe_invert,          // Empty pin inverted
  input wire logic       i_ibf_invert,          // Full pin inverted
  input wire logic       host_chip_select_n,    // Chip select
  input wire logic       host_read_strobe,      // Split read strobe
  input wire logic       host_write_strobe,     // Split write strobe
  input wire logic       host_data_strobe,      // Data strobe
  input wire logic       host_read_write_dir,   // Direction
  input wire logic       status_select,         // Status select
  input wire logic       byte_half_select,      // Half select
  input wire logic [7:0] host_byte_from_dev,    // Device byte
  input wire logic       host_byte_dev_oe,      // Device drives bus
  input wire logic       out_buffer_empty_flag, // Empty pin
  input wire logic       in_buffer_full_flag    // Full pin
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Framing seen from the pins; direction line only sets the read kind in strobe mode
  logic act;  // Frame open
  logic rd;   // Frame is a read
  assign act = !host_chip_select_n && (i_mode_ds ? host_data_strobe == i_ds_active_high
               : (!host_read_strobe || !host_write_strobe));
  assign rd = i_mode_ds ? host_read_write_dir : !host_read_strobe;
  // ==========================================================
  // Assertions
  a_rst_flags: assert property ($rose(i_rst_n) |-> out_buffer_empty_flag && !in_buffer_full_flag)
    else $error("flags wrong after reset");
  a_read_start: assert property ($rose(act) && rd |=> host_byte_dev_oe)
    else $error("read did not drive bus");
  a_frame_end: assert property ($fell(act) |=> !host_byte_dev_oe)
    else $error("bus held after frame end");
  a_write_quiet: assert property (act && !rd |=> !host_byte_dev_oe)
    else $error("bus driven in write");
  a_idle_quiet: assert property (!act [*3] |-> !host_byte_dev_oe)
    else $error("bus driven outside frame");
  a_empty_flag: assert property ($fell(act) && $past(rd && byte_half_select && !status_select)
    |=> out_buffer_empty_flag == !i_obe_invert)
    else $error("empty pin not set");
  a_full_flag: assert property ($fell(act) && $past(!rd && byte_half_select)
    |=> in_buffer_full_flag == !i_ibf_invert)
    else $error("full pin not set");
  a_status_byte: assert property (host_byte_dev_oe && status_select
    |-> host_byte_from_dev[7:2] == 6'h00)
    else $error("status byte upper bits set");
endmodule

// >>> dv/phph_tb.sv
// Testbench: host sequencer driving the device end through the pins
module phph_tb
  import phph_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk, i_rst_n, i_wr, i_rd, o_irq, rd_d;  // Bus and clock
  logic        i_mode_ds, i_ds_active_high, i_obe_invert, i_ibf_invert;  // Device setup
  logic        i_load, i_take, o_out_empty, o_in_full;   // Device user side
  logic [7:0]  i_addr;                                     // Register address
  logic [31:0] i_wdata, o_rdata;                           // Register data
  logic [15:0] i_load_word, o_in_word, w;                  // Words
  logic [3:0]  c;                                          // Control base
  logic [31:0] exp_q[$];                                   // Expected reads
  int          error_cnt, checked;                         // Counters
  phph_if phph_if_i ();
  phph_host phph_host_i (.i_clk, .i_rst_n, .port(phph_if_i), .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .o_irq);
  phph_device phph_device_i (.i_clk, .i_rst_n, .port(phph_if_i), .i_mode_ds, .i_ds_active_high,
    .i_obe_invert, .i_ibf_invert, .i_load, .i_load_word, .i_take, .o_in_word, .o_out_empty,
    .o_in_full);
  phph_sva phph_sva_i (.i_clk, .i_rst_n, .i_mode_ds, .i_ds_active_high, .i_obe_invert,
    .i_ibf_invert, .host_chip_select_n(phph_if_i.host_chip_select_n),
    .host_read_strobe(phph_if_i.host_read_strobe), .host_write_strobe(phph_if_i.host_write_strobe),
    .host_data_strobe(phph_if_i.host_data_strobe), .status_select(phph_if_i.status_select),
    .host_read_write_dir(phph_if_i.host_read_write_dir),
    .byte_half_select(phph_if_i.byte_half_select), .host_byte_dev_oe(phph_if_i.host_byte_dev_oe),
    .host_byte_from_dev(phph_if_i.host_byte_from_dev),
    .out_buffer_empty_flag(phph_if_i.out_buffer_empty_flag),
    .in_buffer_full_flag(phph_if_i.in_buffer_full_flag));
  // ==========================================================
  // Clock, 100 ns period
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One register access; strobe dropped a cycle later so no double drive
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= wr;
    i_rd <= !wr;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // Start a transfer, wait for its interrupt (bounded), clear it
  task automatic go(input logic [3:0] ctl, input logic [1:0] cmd);
    int n;
    n = 0;
    bus(1'b1, REG_CTRL, {28'h0, ctl});
    bus(1'b1, REG_CMD, {30'h0, cmd});
    while (o_irq !== 1'b1 && n < 40)
    begin
      @(posedge i_clk);
      n++;
    end
    chk("irq_done", 32'h1, {31'h0, o_irq});
    bus(1'b1, REG_IRQ_STAT, 32'h1);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================
  // Result watcher: read data stands one cycle after the strobe
  always @(posedge i_clk)
  begin
    if (rd_d)
      chk("rdata", exp_q.pop_front(), o_rdata);
    rd_d <= i_rd;
  end
  // Watchdog well past the expected few hundred cycles
  initial
  begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    tally_and_finish();
  end
  // ==========================================================
  // Main sequence: split, strobe active low, strobe active high
  initial
  begin
    {i_rst_n, i_wr, i_rd, i_load, i_take} = '0;
    {i_mode_ds, i_ds_active_high, i_obe_invert, i_ibf_invert} = '0;
    {i_addr, i_wdata, i_load_word} = '0;
    error_cnt = 0;
    checked = 0;
    void'($urandom(32'hb8d9));
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus(1'b1, REG_IRQ_MASK, 32'h1);
    for (int m = 0; m < 3; m++)
    begin
      w = 16'($urandom);
      c = {2'b00, m == 2, m != 0};
      @(posedge i_clk);
      i_mode_ds <= (m != 0);
      i_ds_active_high <= (m == 2);
      {i_obe_invert, i_ibf_invert} <= 2'($urandom);
      i_load <= 1'b1;
      i_load_word <= w;
      @(posedge i_clk);
      i_load <= 1'b0;
      go(c | 4'h4, 2'h1);
      rdx(REG_RDATA, 32'h0);
      go(c, 2'h1);
      rdx(REG_RDATA, {24'h0, w[7:0]});
      go(c | 4'h8, 2'h1);
      rdx(REG_RDATA, {24'h0, w[15:8]});
      chk("out_empty", 32'h1, {31'h0, o_out_empty});
      w = 16'($urandom);
      bus(1'b1, REG_WDATA, {24'h0, w[7:0]});
      go(c, 2'h2);
      bus(1'b1, REG_WDATA, {24'h0, w[15:8]});
      go(c | 4'h8, 2'h2);
      chk("in_word", {16'h0, w}, {16'h0, o_in_word});
      // Status byte again with both flags raised, so its bits are not all zero
      go(c | 4'h4, 2'h1);
      rdx(REG_RDATA, 32'h3);
      rdx(REG_FLAGS, {30'h0, !i_ibf_invert, !i_obe_invert});
      @(posedge i_clk);
      i_take <= 1'b1;
      @(posedge i_clk);
      i_take <= 1'b0;
      @(posedge i_clk);
      chk("in_full", 32'h0, {31'h0, o_in_full});
    end
    // Masked completion stays silent but still latches
    bus(1'b1, REG_IRQ_MASK, 32'h0);
    bus(1'b1, REG_CMD, 32'h1);
    rdx(REG_CMD, 32'h1);
    repeat (12) @(posedge i_clk);
    chk("irq_masked", 32'h0, {31'h0, o_irq});
    rdx(REG_IRQ_STAT, 32'h1);
    bus(1'b1, REG_IRQ_STAT, 32'h1);
    rdx(REG_IRQ_STAT, 32'h0);
    rdx(8'hfc, 32'h0);
    // Setup registers read back what the last transfer used
    rdx(REG_CTRL, {28'h0, c | 4'h4});
    rdx(REG_WDATA, {24'h0, w[15:8]});
    repeat (4) @(posedge i_clk);
    tally_and_finish();
  end
endmodule
